/* hw/tas_pkg.sv */
package tas_pkg;
  // Clock and timing
  localparam int CLK_HZ = 100_000_000;
  localparam int ROUND_MS = 190;
  localparam int ROUND_CYC = ROUND_MS * (CLK_HZ / 1000);
  localparam int TOUT_MS = 35;
  localparam int TOUT_CYC = TOUT_MS * (CLK_HZ / 1000) + 1;
  localparam int SCL_HALF_NS = 80;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * (CLK_HZ / 1_000_000)) / 1000;
  // Channels: 0 local, 1..4 remote
  localparam int NCH = 5;
  // Slave address, value arbitrary
  localparam logic [6:0] SLV_ADDR = 7'h2a;
  // Pointer values
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [3:0] PTR_MSB_HI = 4'h1;
  localparam logic [3:0] PTR_LSB_HI = 4'h2;
  localparam logic [7:0] REG_STAT1 = 8'h02;
  localparam logic [7:0] REG_STAT2 = 8'h03;
  localparam logic [7:0] REG_STAT3 = 8'h04;
  localparam logic [7:0] REG_STAT4 = 8'h05;
  localparam logic [7:0] REG_CHEN = 8'h06;
  localparam logic [7:0] REG_HYST = 8'h07;
  localparam logic [7:0] REG_MASK1 = 8'h08;
  localparam logic [7:0] REG_LIM_A = 8'h40;
  localparam logic [7:0] REG_LIM_B = 8'h49;
  // Status 1 bit positions
  localparam int REMOTE1_DIODE_MISSING_FLAG_BIT = 1;
  localparam int REMOTE2_DIODE_MISSING_FLAG_BIT = 0;
  // Reset values and fault readings
  localparam logic [7:0] CHEN_RST = 8'h1f;
  localparam logic [7:0] HYST_RST = 8'h05;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] LIM_85 = 8'h55;
  localparam logic [7:0] LIM_110 = 8'h6e;
  localparam logic [15:0] FAULT_S = 16'h8000;
  localparam logic [15:0] FAULT_U = 16'h0000;
  // Host operations
  typedef logic [1:0] tas_op_t;
  localparam tas_op_t OP_WR = 2'h0;
  localparam tas_op_t OP_SETRD = 2'h1;
  localparam tas_op_t OP_RDCUR = 2'h2;
  typedef enum {S_IDLE, S_ADDR, S_AACK, S_CMD, S_CACK, S_WR, S_WACK, S_RD, S_RACK} tas_slv_e;
  typedef enum {H_IDLE, H_START, H_ADDR, H_PTR, H_DATA, H_RSTART, H_RADDR, H_READ, H_STOP} tas_hst_e;
endpackage : tas_pkg

/* hw/tas_smb_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tas_smb_if;
  logic scl_host_o;
  logic scl_host_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;
  // Wired-AND of the open-drain drivers, pulled up when nobody drives
  assign scl = scl_host_oe ? scl_host_o : 1'b1;
  assign sda = (sda_host_oe ? sda_host_o : 1'b1) & (sda_dev_oe ? sda_dev_o : 1'b1);
  modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (input sda, output scl_host_o, output scl_host_oe, output sda_host_o,
                output sda_host_oe);
endinterface : tas_smb_if
`default_nettype wire

/* hw/tas_lim_cmp.sv */
`timescale 1ns/1ps
`default_nettype none
module tas_lim_cmp (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Compare request
  input wire logic i_upd,
  input wire logic i_en,
  input wire logic [15:0] i_temp,
  input wire logic [7:0] i_lim,
  input wire logic [7:0] i_hyst,
  // Latched result
  output logic o_over
);
  logic next_over;
  logic signed [17:0] t;
  logic signed [17:0] hi;
  logic signed [17:0] lo;

  // Set above the limit, hold until below limit minus hysteresis
  always_comb begin
    t = {{2{i_temp[15]}}, i_temp};
    hi = {{2{i_lim[7]}}, i_lim, 8'h00};
    lo = hi - {2'h0, i_hyst, 8'h00};
    next_over = o_over;
    if (i_upd) begin
      if (!i_en) begin
        next_over = 1'b0;
      end else if (t > hi) begin
        next_over = 1'b1;
      end else if (t < lo) begin
        next_over = 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_over <= 1'b0;
    end else begin
      o_over <= next_over;
    end
  end
endmodule : tas_lim_cmp
`default_nettype wire

/* hw/tas_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module tas_dev #(
  parameter int ROUND_CYCLES = tas_pkg::ROUND_CYC,
  parameter int TOUT_CYCLES = tas_pkg::TOUT_CYC,
  parameter logic [6:0] DEV_ADDR = tas_pkg::SLV_ADDR
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Conversion side
  input wire logic [tas_pkg::NCH-1:0][15:0] i_temp,
  input wire logic i_temp_valid,
  input wire logic [3:0] i_diode_fault,
  output logic o_round_start,
  // Alarm pins, open drain
  output logic [2:0] o_alarm_o,
  output logic [2:0] o_alarm_oe,
  // Serial bus
  tas_smb_if.dev smb
);
  import tas_pkg::*;

  tas_slv_e st, next_st;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh, tx, next_tx, ptr, next_ptr;
  logic rw, next_rw, mack, next_mack, sda_oe, next_sda_oe;
  logic [31:0] tcnt, next_tcnt;
  logic [NCH-1:0][15:0] hold, next_hold;
  logic [NCH-1:0] lock, next_lock;
  logic [7:0] chen, next_chen, hyst, next_hyst;
  logic [2:0][7:0] mask, next_mask;
  logic [NCH-1:0][7:0] lim_a, next_lim_a;
  logic [1:0][7:0] lim_b, next_lim_b;
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic rise, fall, start, stop, load;
  logic is_msb, is_lsb;
  logic [2:0] ch;
  logic [7:0] fb;
  logic [15:0] w;
  logic [NCH-1:0][15:0] temp, next_temp;
  logic [7:0] stat1, next_stat1;
  logic [31:0] rcnt, next_rcnt;
  logic rstart, next_rstart, upd, next_upd;
  logic [2:0] al, next_al;
  logic [NCH-1:0] ov_a;
  logic [1:0] ov_b;
  logic [2:0][7:0] stat;

  // Unsigned view clamps negatives, so a faulted channel reads 0
  function automatic logic [15:0] view(input logic [15:0] v, input logic uns);
    view = (uns && v[15]) ? FAULT_U : v;
  endfunction : view

  // Channel result pointers: low nibble 0..4 signed, 9..c unsigned
  function automatic logic ch_ok(input logic [7:0] p);
    ch_ok = (p[2:0] <= 3'h4) && !(p[3] && p[2:0] == 3'h0);
  endfunction : ch_ok

  // Bus pins come from another domain, two stages before use
  always_ff @(posedge i_ref_clk) begin
    scl_s1 <= smb.scl;
    scl_s2 <= scl_s1;
    scl_d <= scl_s2;
    sda_s1 <= smb.sda;
    sda_s2 <= sda_s1;
    sda_d <= sda_s2;
  end

  assign rise = scl_s2 & ~scl_d;
  assign fall = ~scl_s2 & scl_d;
  assign start = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop = scl_s2 & scl_d & ~sda_d & sda_s2;

  // Comparison results per alarm output
  assign stat[0] = {3'h0, ov_a};
  assign stat[1] = {3'h0, ov_a[4:3], ov_b, ov_a[0]};
  assign stat[2] = stat[1];

  // Byte fetch for the current pointer, with its freeze side effect
  always_comb begin
    ch = ptr[2:0];
    is_msb = (ptr[7:4] == PTR_MSB_HI && ch_ok(ptr)) || ptr == PTR_RST;
    is_lsb = ptr[7:4] == PTR_LSB_HI && ch_ok(ptr);
    w = 16'h0000;
    fb = 8'h00;
    if (is_msb) begin
      w = view(temp[ch], ptr[3]);
      fb = w[15:8];
    end else if (is_lsb) begin
      w = view(lock[ch] ? hold[ch] : temp[ch], ptr[3]);
      fb = w[7:0];
    end else begin
      case (ptr)
        REG_STAT1: fb = stat1;
        REG_STAT2: fb = stat[0];
        REG_STAT3: fb = stat[1];
        REG_STAT4: fb = stat[2];
        REG_CHEN: fb = chen;
        REG_HYST: fb = hyst;
        default: fb = 8'h00;
      endcase
      for (int n = 0; n < 3; n++) begin
        if (ptr == 8'(REG_MASK1 + n)) fb = mask[n];
      end
      for (int c = 0; c < NCH; c++) begin
        if (ptr == 8'(REG_LIM_A + c)) fb = lim_a[c];
      end
      for (int c = 0; c < 2; c++) begin
        if (ptr == 8'(REG_LIM_B + c)) fb = lim_b[c];
      end
    end
  end

  // Serial slave: start/stop detect, bit engine, registers
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_sh = sh;
    next_tx = tx;
    next_ptr = ptr;
    next_rw = rw;
    next_mack = mack;
    next_sda_oe = sda_oe;
    next_hold = hold;
    next_lock = lock;
    next_chen = chen;
    next_hyst = hyst;
    next_mask = mask;
    next_lim_a = lim_a;
    next_lim_b = lim_b;
    load = 1'b0;
    next_tcnt = (scl_s2 && sda_s2) ? 32'h0 : ((tcnt < 32'(TOUT_CYCLES)) ? tcnt + 32'h1 : tcnt);
    if (rise) begin
      next_cnt = 4'(cnt + 4'h1);
      if (cnt < 4'h8) next_sh = {sh[6:0], sda_s2};
      else next_mack = sda_s2;
    end
    if (tcnt >= 32'(TOUT_CYCLES) || stop) begin
      next_st = S_IDLE;
      next_sda_oe = 1'b0;
    end else if (start) begin
      next_st = S_ADDR;
      next_cnt = 4'h0;
      next_sda_oe = 1'b0;
    end else if (fall) begin
      unique case (st)
        S_IDLE: next_st = S_IDLE;
        S_ADDR: if (cnt == 4'h8) begin
          next_st = (sh[7:1] == DEV_ADDR) ? S_AACK : S_IDLE;
          next_sda_oe = sh[7:1] == DEV_ADDR;
          next_rw = sh[0];
        end
        S_AACK: begin
          next_cnt = 4'h0;
          next_st = rw ? S_RD : S_CMD;
          load = rw;
          next_sda_oe = rw & ~fb[7];
        end
        S_CMD: if (cnt == 4'h8) begin
          next_st = S_CACK;
          next_sda_oe = 1'b1;
        end
        S_CACK: begin
          next_ptr = sh;
          next_cnt = 4'h0;
          next_st = S_WR;
          next_sda_oe = 1'b0;
        end
        S_WR: if (cnt == 4'h8) begin
          next_st = S_WACK;
          next_sda_oe = 1'b1;
          if (ptr == REG_CHEN) next_chen = sh;
          if (ptr == REG_HYST) next_hyst = sh;
          for (int n = 0; n < 3; n++) begin
            if (ptr == 8'(REG_MASK1 + n)) next_mask[n] = sh;
          end
          for (int c = 0; c < NCH; c++) begin
            if (ptr == 8'(REG_LIM_A + c)) next_lim_a[c] = sh;
          end
          for (int c = 0; c < 2; c++) begin
            if (ptr == 8'(REG_LIM_B + c)) next_lim_b[c] = sh;
          end
        end
        S_WACK: begin
          next_st = S_IDLE; // further data bytes are not acknowledged
          next_sda_oe = 1'b0;
        end
        S_RD: if (cnt == 4'h8) begin
          next_st = S_RACK;
          next_sda_oe = 1'b0;
        end else begin
          next_tx = {tx[6:0], 1'b0};
          next_sda_oe = ~tx[6];
        end
        S_RACK: begin
          next_cnt = 4'h0;
          next_st = mack ? S_IDLE : S_RD;
          load = ~mack;
          next_sda_oe = ~mack & ~fb[7];
        end
      endcase
    end
    if (load) begin
      next_tx = fb;
      if (is_msb) begin
        next_hold[ch] = temp[ch];
        next_lock[ch] = 1'b1;
      end else if (is_lsb) begin
        next_lock[ch] = 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      st <= S_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      tx <= 8'h00;
      ptr <= PTR_RST;
      rw <= 1'b0;
      mack <= 1'b0;
      sda_oe <= 1'b0;
      tcnt <= 32'h0;
      hold <= '0;
      lock <= '0;
      chen <= CHEN_RST;
      hyst <= HYST_RST;
      mask <= {3{MASK_RST}};
      lim_a <= {LIM_85, LIM_85, LIM_110, LIM_110, LIM_85};
      lim_b <= {LIM_85, LIM_85};
      smb.sda_dev_o <= 1'b0;
      smb.sda_dev_oe <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      sh <= next_sh;
      tx <= next_tx;
      ptr <= next_ptr;
      rw <= next_rw;
      mack <= next_mack;
      sda_oe <= next_sda_oe;
      tcnt <= next_tcnt;
      hold <= next_hold;
      lock <= next_lock;
      chen <= next_chen;
      hyst <= next_hyst;
      mask <= next_mask;
      lim_a <= next_lim_a;
      lim_b <= next_lim_b;
      smb.sda_dev_o <= 1'b0;
      smb.sda_dev_oe <= next_sda_oe;
    end
  end

  // One comparator per limit; remotes 1 and 2 have a second limit
  for (genvar c = 0; c < NCH; c++) begin : g_lim_a
    tas_lim_cmp u_cmp (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_upd(upd),
      .i_en(chen[c]),
      .i_temp(temp[c]),
      .i_lim(lim_a[c]),
      .i_hyst(hyst),
      .o_over(ov_a[c])
    );
  end
  for (genvar c = 0; c < 2; c++) begin : g_lim_b
    tas_lim_cmp u_cmp (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_upd(upd),
      .i_en(chen[c+1]),
      .i_temp(temp[c+1]),
      .i_lim(lim_b[c]),
      .i_hyst(hyst),
      .o_over(ov_b[c])
    );
  end

  // Round timer, result capture, fault forcing and alarm drive
  always_comb begin
    next_rstart = rcnt == 32'(ROUND_CYCLES - 1);
    next_rcnt = next_rstart ? 32'h0 : rcnt + 32'h1;
    next_temp = temp;
    next_stat1 = stat1;
    next_upd = i_temp_valid; // compare one cycle after capture
    if (i_temp_valid) begin
      next_temp[0] = i_temp[0];
      for (int c = 1; c < NCH; c++) begin
        next_temp[c] = i_diode_fault[c-1] ? FAULT_S : i_temp[c];
      end
      next_stat1 = 8'h00;
      next_stat1[REMOTE1_DIODE_MISSING_FLAG_BIT] = i_diode_fault[0];
      next_stat1[REMOTE2_DIODE_MISSING_FLAG_BIT] = i_diode_fault[1];
    end
    for (int n = 0; n < 3; n++) begin
      next_al[n] = |(stat[n] & ~mask[n]);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      rcnt <= 32'h0;
      rstart <= 1'b0;
      temp <= '0;
      stat1 <= 8'h00;
      upd <= 1'b0;
      al <= 3'h0;
      o_alarm_o <= 3'h0;
    end else begin
      rcnt <= next_rcnt;
      rstart <= next_rstart;
      temp <= next_temp;
      stat1 <= next_stat1;
      upd <= next_upd;
      al <= next_al;
      o_alarm_o <= 3'h0;
    end
  end

  assign o_round_start = rstart;
  assign o_alarm_oe = al;
endmodule : tas_dev
`default_nettype wire

/* hw/tas_host.sv */
`timescale 1ns/1ps
`default_nettype none
module tas_host #(
  parameter int HALF = tas_pkg::SCL_HALF_CYC,
  parameter logic [6:0] DEV_ADDR = tas_pkg::SLV_ADDR
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Command port
  input wire logic i_req,
  input wire tas_pkg::tas_op_t i_op,
  input wire logic [7:0] i_ptr,
  input wire logic [7:0] i_wdata,
  output logic o_busy,
  output logic o_done,
  output logic o_nack,
  output logic [7:0] o_rdata,
  // Serial bus
  tas_smb_if.host smb
);
  import tas_pkg::*;

  tas_hst_e st, next_st;
  tas_op_t op, next_op;
  logic [1:0] ph, next_ph;
  logic [3:0] bi, next_bi;
  logic [7:0] tx, next_tx, rx, next_rx, ptr, next_ptr, wd, next_wd;
  logic [15:0] dv, next_dv;
  logic done, next_done, nack, next_nack, scl_oe, next_scl_oe, sda_oe, next_sda_oe;
  logic sda_s1, sda_s2, tick;

  // Pin levels for each phase; bits are driven while the clock is low
  function automatic logic [1:0] drv(input tas_hst_e s, input logic [1:0] p,
                                     input logic [3:0] b, input logic [7:0] t);
    drv = 2'h0;
    unique case (s)
      H_IDLE: drv = 2'h0;
      H_START, H_RSTART: drv = {p == 2'h0, p == 2'h2};
      H_STOP: drv = {p == 2'h0, p != 2'h2};
      H_READ: drv = {p == 2'h0, 1'b0}; // not-ack ends the read
      default: drv = {p == 2'h0, b < 4'h8 && !t[7]};
    endcase
  endfunction : drv

  always_ff @(posedge i_ref_clk) begin
    sda_s1 <= smb.sda;
    sda_s2 <= sda_s1;
  end

  assign tick = dv == 16'(HALF - 1);

  // Sequencer: one phase per half clock period
  always_comb begin
    next_st = st;
    next_op = op;
    next_ph = ph;
    next_bi = bi;
    next_tx = tx;
    next_rx = rx;
    next_ptr = ptr;
    next_wd = wd;
    next_nack = nack;
    next_done = 1'b0;
    next_dv = (st == H_IDLE || tick) ? 16'h0 : 16'(dv + 16'h1);
    if (st == H_IDLE) begin
      if (i_req) begin
        next_st = H_START;
        next_op = i_op;
        next_ptr = i_ptr;
        next_wd = i_wdata;
        next_nack = 1'b0;
        next_ph = 2'h0;
      end
    end else if (tick) begin
      next_ph = 2'(ph + 2'h1);
      unique case (st)
        H_START, H_RSTART: if (ph == 2'h2) begin
          next_ph = 2'h0;
          next_bi = 4'h0;
          next_st = (st == H_START) ? H_ADDR : H_RADDR;
          next_tx = {DEV_ADDR, st == H_RSTART || op == OP_RDCUR};
        end
        H_STOP: if (ph == 2'h2) begin
          next_st = H_IDLE;
          next_done = 1'b1;
        end
        H_READ: if (ph == 2'h1) begin
          next_ph = 2'h0;
          next_bi = 4'(bi + 4'h1);
          if (bi < 4'h8) next_rx = {rx[6:0], sda_s2};
          else next_st = H_STOP;
        end
        default: if (ph == 2'h1) begin
          next_ph = 2'h0;
          next_bi = 4'(bi + 4'h1);
          next_tx = {tx[6:0], 1'b0};
          if (bi == 4'h8) begin
            next_bi = 4'h0;
            if (sda_s2) begin
              next_st = H_STOP;
              next_nack = 1'b1;
            end else if (st == H_ADDR) begin
              next_st = (op == OP_RDCUR) ? H_READ : H_PTR;
              next_tx = ptr;
            end else if (st == H_PTR) begin
              next_st = (op == OP_WR) ? H_DATA : H_RSTART;
              next_tx = wd;
            end else begin
              next_st = (st == H_DATA) ? H_STOP : H_READ; // one data byte
            end
          end
        end
      endcase
    end
    {next_scl_oe, next_sda_oe} = drv(next_st, next_ph, next_bi, next_tx);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      st <= H_IDLE;
      op <= OP_WR;
      ph <= 2'h0;
      bi <= 4'h0;
      tx <= 8'h00;
      rx <= 8'h00;
      ptr <= 8'h00;
      wd <= 8'h00;
      dv <= 16'h0;
      done <= 1'b0;
      nack <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      st <= next_st;
      op <= next_op;
      ph <= next_ph;
      bi <= next_bi;
      tx <= next_tx;
      rx <= next_rx;
      ptr <= next_ptr;
      wd <= next_wd;
      dv <= next_dv;
      done <= next_done;
      nack <= next_nack;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
    end
  end

  assign o_busy = st != H_IDLE;
  assign o_done = done;
  assign o_nack = nack;
  assign o_rdata = rx;
  assign smb.scl_host_o = 1'b0;
  assign smb.sda_host_o = 1'b0;
  assign smb.scl_host_oe = scl_oe;
  assign smb.sda_host_oe = sda_oe;
endmodule : tas_host
`default_nettype wire

/* verification/tas_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module tas_chk #(
  parameter int TOUT = 2000
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Bus lines and drivers
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_host_o,
  input wire logic scl_host_oe,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe
);
  int low_cnt;
  int next_low_cnt;
  // Low time of either line; a stuck party shows up here long before a hang
  always_comb begin
    next_low_cnt = (!scl || !sda) ? low_cnt + 1 : 0;
  end
  always_ff @(posedge i_ref_clk) begin
    low_cnt <= i_rst_b ? next_low_cnt : 0;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // Bus conditions
  sequence s_start; scl && $fell(sda); endsequence
  sequence s_stop; scl && $rose(sda); endsequence
  property p_drive_low; !sda_dev_o && !scl_host_o && !sda_host_o; endproperty
  a_drive_low: assert property (p_drive_low) else $error("open drain line driven high");
  property p_dev_hold; scl && $past(scl) |-> $stable(sda_dev_oe); endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("device data moved with clock high");
  property p_rst_idle; $rose(i_rst_b) |-> !scl_host_oe && !sda_host_oe && !sda_dev_oe; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("bus driven right after reset");
  property p_scl_low; $rose(scl_host_oe) |-> scl_host_oe [*8]; endproperty
  a_scl_low: assert property (p_scl_low) else $error("clock low phase too short");
  property p_scl_high; $fell(scl_host_oe) |-> !scl_host_oe [*8]; endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high phase too short");
  property p_start; s_start |-> ##[1:20] !scl; endproperty
  a_start: assert property (p_start) else $error("start not followed by clock");
  property p_stop; s_stop |-> sda [*8]; endproperty
  a_stop: assert property (p_stop) else $error("data fell soon after stop");
  property p_tout; low_cnt < TOUT; endproperty
  a_tout: assert property (p_tout) else $error("bus held low too long");
endmodule : tas_chk
`default_nettype wire

/* verification/thermal_alarm_and_serial_access_test.sv */
`timescale 1ns/1ps
`default_nettype none
module thermal_alarm_and_serial_access_test;
  import tas_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [NCH-1:0][15:0] temp = '0;
  logic temp_valid = 1'b0;
  logic [3:0] fault = 4'h0;
  logic req = 1'b0;
  tas_op_t op = OP_WR;
  logic [7:0] ptr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic busy, done, nack, round_start;
  logic [7:0] rdata;
  logic [2:0] alarm_o, alarm_oe, exp_al;
  logic [NCH-1:0] over [3];
  logic [7:0] mask [3];
  logic [7:0] chen = 8'h1f;
  logic [15:0] tv;
  int n_errors = 0;
  int compares = 0;
  int seed = 15;
  int hyst, lim, i, r, k, c;
  logic [7:0] dp [12] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h49, 8'h4a, 8'h06, 8'h07,
                          8'h08, 8'h09, 8'h0a};
  logic [7:0] dv [12] = '{8'h55, 8'h6e, 8'h6e, 8'h55, 8'h55, 8'h55, 8'h55, 8'h1f, 8'h05,
                          8'h00, 8'h00, 8'h00};
  tas_smb_if smb ();
  // Free running 100 MHz clock
  always #5 i_ref_clk = ~i_ref_clk;
  // Both ends joined on one bus
  tas_dev #(.ROUND_CYCLES(200), .TOUT_CYCLES(2000)) i_tas_dev (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .i_temp(temp), .i_temp_valid(temp_valid), .i_diode_fault(fault),
    .o_round_start(round_start), .o_alarm_o(alarm_o), .o_alarm_oe(alarm_oe), .smb(smb));
  tas_host i_tas_host (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_req(req), .i_op(op),
    .i_ptr(ptr), .i_wdata(wdata), .o_busy(busy), .o_done(done), .o_nack(nack),
    .o_rdata(rdata), .smb(smb));
  tas_chk #(.TOUT(2000)) i_tas_chk (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .scl(smb.scl),
    .sda(smb.sda), .scl_host_o(smb.scl_host_o), .scl_host_oe(smb.scl_host_oe),
    .sda_host_o(smb.sda_host_o), .sda_host_oe(smb.sda_host_oe), .sda_dev_o(smb.sda_dev_o),
    .sda_dev_oe(smb.sda_dev_oe));
  task automatic summarize();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One host command; the next may only start after done, so wait for it
  task automatic xfer(input tas_op_t o, input logic [7:0] p, input logic [7:0] d);
    int j;
    @(posedge i_ref_clk);
    req <= 1'b1;
    op <= o;
    ptr <= p;
    wdata <= d;
    @(posedge i_ref_clk);
    req <= 1'b0;
    @(posedge i_ref_clk);
    chk({7'h0, busy}, 8'h01);
    for (j = 0; j < 3000 && done !== 1'b1; j++) @(posedge i_ref_clk);
    if (j == 3000) begin
      n_errors++;
      summarize();
    end
    chk({7'h0, nack}, 8'h00);
  endtask : xfer
  task automatic rd(input logic [7:0] p, input logic [7:0] exp);
    xfer(OP_SETRD, p, 8'h00);
    chk(rdata, exp);
  endtask : rd
  // Capture pulse, then let the alarm pins settle
  task automatic push();
    @(posedge i_ref_clk);
    temp_valid <= 1'b1;
    @(posedge i_ref_clk);
    temp_valid <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
  endtask : push
  // Expected pins from latched flags and per-output masks
  function automatic logic [2:0] alarms();
    for (int m = 0; m < 3; m++) alarms[m] = |(over[m] & ~mask[m][NCH-1:0]);
  endfunction : alarms
  initial begin
    for (k = 0; k < 3; k++) begin
      over[k] = '0;
      mask[k] = 8'h00;
    end
    hyst = 5;
    repeat (10) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    temp[0] <= 16'h1900;
    push();
    xfer(OP_RDCUR, 8'h00, 8'h00);
    chk(rdata, 8'h19);
    for (i = 0; i < 12; i++) rd(dp[i], dv[i]);
    xfer(OP_WR, REG_HYST, 8'h06);
    xfer(OP_RDCUR, 8'h00, 8'h00);
    chk(rdata, 8'h06);
    rd(8'hff, 8'h00);
    $display("test defaults done");
    for (r = 0; r < 8; r++) begin
      hyst = $random(seed) & 7;
      xfer(OP_WR, REG_HYST, 8'(hyst));
      for (k = 0; k < 3; k++) begin
        mask[k] = 8'($random(seed) & 32'h1f);
        xfer(OP_WR, REG_MASK1 + 8'(k), mask[k]);
      end
      if (r == 7) begin
        chen = 8'h1e;
        xfer(OP_WR, REG_CHEN, chen);
      end
      for (c = 0; c < NCH; c++) begin
        tv = 16'((78 + (($random(seed) & 32'h7fffffff) % 40)) * 256 + (($random(seed) & 7) * 32));
        temp[c] <= tv;
        for (k = 0; k < 3; k++) begin
          lim = (k == 0 && (c == 1 || c == 2)) ? 110 * 256 : 85 * 256;
          if (!chen[c]) over[k][c] = 1'b0;
          else if ($signed(tv) > lim) over[k][c] = 1'b1;
          else if ($signed(tv) < lim - hyst * 256) over[k][c] = 1'b0;
        end
      end
      push();
      exp_al = alarms();
      chk({5'h0, alarm_oe}, {5'h0, exp_al});
      for (k = 0; k < 3; k++) rd(REG_STAT2 + 8'(k), {3'h0, over[k]});
    end
    $display("test compare done");
    temp[1] <= 16'h1a20;
    push();
    rd(8'h11, 8'h1a);
    temp[1] <= 16'h1b40;
    push();
    rd(8'h11, 8'h1b);
    temp[1] <= 16'h1c60;
    push();
    rd(8'h21, 8'h40);
    rd(8'h21, 8'h60);
    $display("test freeze done");
    fault <= 4'h3;
    push();
    rd(8'h11, 8'h80);
    rd(8'h19, 8'h00);
    rd(REG_STAT1, 8'h03);
    fault <= 4'h4;
    push();
    rd(REG_STAT1, 8'h00);
    rd(8'h13, 8'h80);
    $display("test fault done");
    for (i = 0; i < 400 && round_start !== 1'b1; i++) @(posedge i_ref_clk);
    // A round pulse that never comes is a failure, not a hang
    if (i == 400) begin
      n_errors++;
      summarize();
    end
    for (i = 1; i < 400; i++) begin
      @(posedge i_ref_clk);
      if (round_start === 1'b1) break;
    end
    chk(8'(i), 8'd200);
    $display("test round done");
    summarize();
  end
endmodule : thermal_alarm_and_serial_access_test
`default_nettype wire
